//--- design/obm_mapper.sv
// obm_mapper: packs client constant-bit-rate bits into payload bytes and serialises
// a row/column transport frame onto one line bit per core_clk cycle
// assumes the client source and n_inst sit on core_clk; n_inst in 1..4
// How it works
// - frame leaves row by row, each row from leftmost to rightmost byte
// - each byte goes out most significant bit first
// - most significant bit is bit 1, least significant is bit 8
// - client bits leave on the line in arrival order
// - first client bit lands in bit 1, eighth bit in bit 8 of its byte
// - reserved overhead bits are sent as zero
// - any bit the block does not source is sent as zero
// - a single-rate frame carries exactly one overhead instance
// - an n-fold frame carries n interleaved overhead instances numbered 1 to n
`timescale 1ns/1ps
`default_nettype none
module obm_mapper
    import obm_pkg::*;
(
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    // configuration
    input  wire logic [obm_pkg::INST_W-1:0]  n_inst,
    // client bit stream
    input  wire logic                        cl_bit,
    input  wire logic                        cl_valid,
    output logic                             cl_ready,
    // line side
    output logic                             line_bit,
    output logic                             line_frame_start,
    output logic                             line_oh,
    output logic                             line_payload_valid,
    output logic [obm_pkg::INST_W-1:0]       line_inst,
    output logic [obm_pkg::ROW_W-1:0]        line_row
);
    import obm_pkg::*;

    // columns of an n-fold interleaved row for a per-instance count
    function automatic logic [COL_W-1:0] scaled_cols(input logic [INST_W-1:0] n,
                                                     input logic [COL_W-1:0]  per);
        scaled_cols = COL_W'(per * n);
    endfunction

    obm_fifo_if #(.WIDTH(BYTE_W)) fq ();

    obm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH), .PTR_W(FIFO_PTR_W)) u_fifo (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .fq       (fq)
    );

    // client packer
    logic [BYTE_W-1:0]    acc_ff, nxt_acc;
    logic [BIT_IDX_W-1:0] pk_cnt_ff, nxt_pk_cnt;
    logic                 lead_bit_ff, nxt_lead_bit;
    logic                 cl_take;

    always_comb
    begin
        // a byte only completes if the fifo can take it, so the client stalls
        cl_ready      = (pk_cnt_ff != LAST_BIT) || fq.push_ready;
        cl_take       = cl_valid && cl_ready;
        fq.push_valid = cl_valid && (pk_cnt_ff == LAST_BIT);
        fq.push_data  = {acc_ff[BYTE_W-2:0], cl_bit};
        nxt_acc       = acc_ff;
        nxt_pk_cnt    = pk_cnt_ff;
        // first bit of each byte, kept apart from the shifter for the packing check
        nxt_lead_bit  = lead_bit_ff;
        if (cl_take)
        begin
            nxt_acc    = {acc_ff[BYTE_W-2:0], cl_bit};
            nxt_pk_cnt = BIT_IDX_W'(pk_cnt_ff + 1'b1);
            if (pk_cnt_ff == FIRST_BIT)
                nxt_lead_bit = cl_bit;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_ff      <= ZERO_BYTE;
            pk_cnt_ff   <= FIRST_BIT;
            lead_bit_ff <= 1'b0;
        end
        else
        begin
            acc_ff      <= nxt_acc;
            pk_cnt_ff   <= nxt_pk_cnt;
            lead_bit_ff <= nxt_lead_bit;
        end
    end

    // line serialiser
    logic [BIT_IDX_W-1:0] bit_ff, nxt_bit;
    logic [COL_W-1:0]     col_ff, nxt_col;
    logic [ROW_W-1:0]     row_ff, nxt_row;
    logic [INST_W-1:0]    n_ff, nxt_n;
    logic [INST_W-1:0]    inst_ff, nxt_inst;
    logic [BYTE_W-1:0]    shift_ff, nxt_shift;
    logic                 line_bit_ff, nxt_line_bit;
    logic                 sof_ff, nxt_sof;
    logic                 oh_ff, nxt_oh;
    logic                 pv_ff, nxt_pv;
    logic [INST_W-1:0]    out_inst_ff, nxt_out_inst;
    logic [ROW_W-1:0]     out_row_ff, nxt_out_row;
    logic                 byte_start;
    logic                 in_oh;
    logic                 frame_end;
    logic [BYTE_W-1:0]    load_byte;

    always_comb
    begin
        byte_start   = (bit_ff == FIRST_BIT);
        in_oh        = (col_ff < scaled_cols(n_ff, OH_ONE));
        frame_end    = (bit_ff == LAST_BIT) && (row_ff == LAST_ROW)
                       && (col_ff == COL_W'(scaled_cols(n_ff, COLS_ONE) - 1'b1));
        fq.pop_ready = byte_start && !in_oh;
        // overhead and starved payload slots carry zeros
        load_byte    = (!in_oh && fq.pop_valid) ? fq.pop_data : ZERO_BYTE;
        nxt_bit      = BIT_IDX_W'(bit_ff + 1'b1);
        nxt_col      = col_ff;
        nxt_row      = row_ff;
        nxt_inst     = inst_ff;
        nxt_n        = n_ff;
        nxt_shift    = {shift_ff[BYTE_W-2:0], 1'b0};
        nxt_line_bit = shift_ff[BYTE_W-1];
        nxt_sof      = 1'b0;
        nxt_oh       = oh_ff;
        nxt_pv       = pv_ff;
        nxt_out_inst = out_inst_ff;
        nxt_out_row  = out_row_ff;
        if (byte_start)
        begin
            // bit 1 of the byte is its msb and leaves first
            nxt_line_bit = load_byte[BYTE_W-1];
            nxt_shift    = {load_byte[BYTE_W-2:0], 1'b0};
            nxt_sof      = (col_ff == '0) && (row_ff == '0);
            nxt_oh       = in_oh;
            nxt_pv       = !in_oh && fq.pop_valid;
            nxt_out_inst = inst_ff;
            nxt_out_row  = row_ff;
        end
        if (bit_ff == LAST_BIT)
        begin
            // instances interleave byte by byte, numbered from one
            nxt_inst = (inst_ff == n_ff) ? INST_ONE : INST_W'(inst_ff + 1'b1);
            nxt_col  = COL_W'(col_ff + 1'b1);
            if (col_ff == COL_W'(scaled_cols(n_ff, COLS_ONE) - 1'b1))
            begin
                nxt_col  = '0;
                nxt_row  = ROW_W'(row_ff + 1'b1);
                nxt_inst = INST_ONE;
            end
        end
        if (frame_end)
        begin
            // a new count only takes hold between frames; out-of-range values are ignored
            if ((n_inst >= INST_ONE) && (n_inst <= INST_MAX))
                nxt_n = n_inst;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_ff      <= FIRST_BIT;
            col_ff      <= '0;
            row_ff      <= '0;
            n_ff        <= INST_ONE;
            inst_ff     <= INST_ONE;
            shift_ff    <= ZERO_BYTE;
            line_bit_ff <= 1'b0;
            sof_ff      <= 1'b0;
            oh_ff       <= 1'b0;
            pv_ff       <= 1'b0;
            out_inst_ff <= INST_ONE;
            out_row_ff  <= '0;
        end
        else
        begin
            bit_ff      <= nxt_bit;
            col_ff      <= nxt_col;
            row_ff      <= nxt_row;
            n_ff        <= nxt_n;
            inst_ff     <= nxt_inst;
            shift_ff    <= nxt_shift;
            line_bit_ff <= nxt_line_bit;
            sof_ff      <= nxt_sof;
            oh_ff       <= nxt_oh;
            pv_ff       <= nxt_pv;
            out_inst_ff <= nxt_out_inst;
            out_row_ff  <= nxt_out_row;
        end
    end

    assign line_bit           = line_bit_ff;
    assign line_frame_start   = sof_ff;
    assign line_oh            = oh_ff;
    assign line_payload_valid = pv_ff;
    assign line_inst          = out_inst_ff;
    assign line_row           = out_row_ff;

    // checks
    a_row_walk: assert property (@(posedge core_clk) disable iff (!reset_n)
        (bit_ff == LAST_BIT && col_ff == COL_W'(scaled_cols(n_ff, COLS_ONE) - 1'b1))
        |=> (col_ff == '0 && row_ff == ROW_W'($past(row_ff) + 1'b1)))
        else $error("row did not advance after its last column");
    a_col_step: assert property (@(posedge core_clk) disable iff (!reset_n)
        (bit_ff == LAST_BIT && col_ff < COL_W'(scaled_cols(n_ff, COLS_ONE) - 1'b1))
        |=> (col_ff == COL_W'($past(col_ff) + 1'b1) && row_ff == $past(row_ff)))
        else $error("column did not step left to right");
    a_msb_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fq.pop_ready && fq.pop_valid) |=> line_bit == $past(fq.pop_data[BYTE_W-1]))
        else $error("payload byte did not start with its msb");
    a_byte_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fq.pop_ready && fq.pop_valid)
        |-> ##8 (line_bit == $past(fq.pop_data[0], 8)))
        else $error("payload byte lsb not sent eighth");
    a_byte_pack: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fq.push_valid && fq.push_ready)
        |-> (fq.push_data[0] == cl_bit && fq.push_data[BYTE_W-1] == lead_bit_ff))
        else $error("packed byte does not follow client arrival order");
    a_oh_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_start && in_oh) |=> (!line_bit [*8]))
        else $error("overhead byte carried a one");
    a_starve_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        (byte_start && !in_oh && !fq.pop_valid) |=> (!line_bit [*8]))
        else $error("unsourced payload byte carried a one");
    a_single_inst: assert property (@(posedge core_clk) disable iff (!reset_n)
        (n_ff == INST_ONE) |-> (inst_ff == INST_ONE))
        else $error("single-rate frame shows a second overhead instance");
    a_inst_range: assert property (@(posedge core_clk) disable iff (!reset_n)
        (inst_ff >= INST_ONE) && (inst_ff <= n_ff))
        else $error("overhead instance outside 1 to n");
    a_n_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !$past(frame_end) |-> $stable(n_ff))
        else $error("instance count changed inside a frame");

    c_frame_wrap: cover property (@(posedge core_clk) disable iff (!reset_n) frame_end);
    c_multi_inst: cover property (@(posedge core_clk) disable iff (!reset_n)
        inst_ff == INST_MAX && byte_start);
    c_client_stall: cover property (@(posedge core_clk) disable iff (!reset_n)
        cl_valid && !cl_ready);
endmodule : obm_mapper
`default_nettype wire

//--- design/obm_pkg.sv
// obm_pkg: frame geometry, widths and limits shared by the bit-order mapper files
// assumes one core clock; all figures are fixed at build time
package obm_pkg;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned BIT_IDX_W   = 3;
    localparam int unsigned FRAME_ROWS  = 4;
    localparam int unsigned FRAME_COLS  = 3824;
    localparam int unsigned OH_COLS     = 16;
    localparam int unsigned MAX_INST    = 4;
    localparam int unsigned INST_W      = 3;
    localparam int unsigned COL_W       = 14;
    localparam int unsigned ROW_W       = 2;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned FIFO_PTR_W  = 4;

    localparam logic [BIT_IDX_W-1:0] LAST_BIT   = 3'h7;
    localparam logic [BIT_IDX_W-1:0] FIRST_BIT  = 3'h0;
    localparam logic [ROW_W-1:0]     LAST_ROW   = 2'h3;
    localparam logic [INST_W-1:0]    INST_ONE   = 3'h1;
    localparam logic [INST_W-1:0]    INST_MAX   = 3'h4;
    localparam logic [COL_W-1:0]     COLS_ONE   = 14'hEF0;
    localparam logic [COL_W-1:0]     OH_ONE     = 14'h010;
    localparam logic [BYTE_W-1:0]    ZERO_BYTE  = 8'h00;
endpackage : obm_pkg

//--- design/obm_fifo_if.sv
// obm_fifo_if: byte stream between the client packer and the line serialiser
// assumes both ends sit on core_clk
`timescale 1ns/1ps
`default_nettype none
interface obm_fifo_if #(parameter int unsigned WIDTH = 8);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport src  (output push_valid, output push_data, input push_ready);
    modport buf_side (input push_valid, input push_data, output push_ready,
                      output pop_valid, output pop_data, input pop_ready);
    modport snk  (input pop_valid, input pop_data, output pop_ready);
endinterface : obm_fifo_if
`default_nettype wire

//--- design/obm_fifo.sv
// obm_fifo: parameterised synchronous FIFO with registered show-ahead read data
// assumes push and pop share core_clk; reset is asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module obm_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned PTR_W = 4
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // stream
    obm_fifo_if.buf_side fq
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [PTR_W-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [PTR_W:0]   count_ff, nxt_count;
    logic [WIDTH-1:0] rd_data_ff, nxt_rd_data;
    logic             do_push;
    logic             do_pop;

    assign fq.push_ready = (count_ff != DEPTH[PTR_W:0]);
    assign fq.pop_valid  = (count_ff != '0);
    assign fq.pop_data   = rd_data_ff;

    always_comb
    begin
        do_push     = fq.push_valid && fq.push_ready;
        do_pop      = fq.pop_valid && fq.pop_ready;
        nxt_wr_ptr  = do_push ? PTR_W'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr  = do_pop ? PTR_W'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
        nxt_count   = count_ff;
        if (do_push && !do_pop)
            nxt_count = (PTR_W+1)'(count_ff + 1'b1);
        else if (do_pop && !do_push)
            nxt_count = (PTR_W+1)'(count_ff - 1'b1);
        // bypass keeps the head correct when the word lands on the slot read next
        if (do_push && (wr_ptr_ff == nxt_rd_ptr))
            nxt_rd_data = fq.push_data;
        else
            nxt_rd_data = mem[nxt_rd_ptr];
    end

    always_ff @(posedge core_clk)
    begin
        if (do_push)
            mem[wr_ptr_ff] <= fq.push_data;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            count_ff   <= '0;
            rd_data_ff <= '0;
        end
        else
        begin
            wr_ptr_ff  <= nxt_wr_ptr;
            rd_ptr_ff  <= nxt_rd_ptr;
            count_ff   <= nxt_count;
            rd_data_ff <= nxt_rd_data;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_ff == DEPTH[PTR_W:0]) |-> (!fq.push_ready && wr_ptr_ff == rd_ptr_ff))
        else $error("fifo accepted a word while full");
    a_fifo_one_word: assert property (@(posedge core_clk) disable iff (!reset_n)
        (count_ff == '0 && fq.push_valid) |=> (fq.pop_valid && fq.pop_data == $past(fq.push_data)))
        else $error("fifo head differs from word written into empty fifo");
    c_fifo_fills: cover property (@(posedge core_clk) disable iff (!reset_n)
        count_ff == DEPTH[PTR_W:0]);
endmodule : obm_fifo
`default_nettype wire

//--- tb/obm_client_src.sv
// obm_client_src: client constant-bit-rate source feeding the mapper, one bit per take
// assumes core_clk shared with the mapper; slow mode offers one bit every fourth cycle
`timescale 1ns/1ps
`default_nettype none
module obm_client_src
    import obm_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // pacing
    input  wire logic slow,
    // client stream
    input  wire logic cl_ready,
    output logic      cl_bit,
    output logic      cl_valid
);
    logic [2:0] idx_ff;
    logic [7:0] cur_ff;
    logic [1:0] gap_ff;
    logic [2:0] nxt_idx;
    logic [7:0] nxt_cur;

    initial
    begin
        cl_bit   = 1'b0;
        cl_valid = 1'b0;
    end

    always_comb
    begin
        nxt_idx = idx_ff + {2'h0, cl_valid};
        nxt_cur = (cl_valid && idx_ff == 3'h7) ? cur_ff + 8'h3B : cur_ff;
    end

    // a bit offered is held until taken; idle line toggles each cycle, starting from the inverse of the last bit
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cl_valid <= 1'b0;
            cl_bit   <= 1'b0;
            idx_ff   <= 3'h0;
            cur_ff   <= 8'h5A;
            gap_ff   <= 2'h0;
        end
        else if (!(cl_valid && !cl_ready))
        begin
            idx_ff <= nxt_idx;
            cur_ff <= nxt_cur;
            gap_ff <= cl_valid ? 2'h0 : gap_ff + 2'h1;
            if (!slow || (!cl_valid && gap_ff == 2'h2))
            begin
                cl_valid <= 1'b1;
                cl_bit   <= nxt_cur[3'h7 - nxt_idx];
            end
            else
            begin
                cl_valid <= 1'b0;
                cl_bit   <= ~cl_bit;
            end
        end
    end
endmodule // obm_client_src
`default_nettype wire

//--- tb/obm_mapper_test.sv
// obm_mapper_test: checks line framing, overhead zeroing and client bit order
// assumes single-rate start after reset; frame length is fixed so rows 0 to 2 are watched
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module obm_mapper_test;
    import obm_pkg::*;
    logic                core_clk = 1'b0;
    logic                reset_n  = 1'b0;
    logic [INST_W-1:0]   n_inst   = INST_ONE;
    logic                slow     = 1'b0;
    logic                cl_bit;
    logic                cl_valid;
    logic                cl_ready;
    logic                line_bit;
    logic                line_frame_start;
    logic                line_oh;
    logic                line_payload_valid;
    logic [INST_W-1:0]   line_inst;
    logic [ROW_W-1:0]    line_row;
    int                  n_mismatch = 0;
    int                  tests_run  = 0;
    int                  pos;
    int                  n_empty;
    logic [7:0]          exp_byte;
    logic                saw_full   = 1'b0;

    always #25 core_clk = ~core_clk;

    obm_mapper DUT (.core_clk(core_clk), .reset_n(reset_n), .n_inst(n_inst),
        .cl_bit(cl_bit), .cl_valid(cl_valid), .cl_ready(cl_ready), .line_bit(line_bit),
        .line_frame_start(line_frame_start), .line_oh(line_oh),
        .line_payload_valid(line_payload_valid), .line_inst(line_inst), .line_row(line_row));

    obm_client_src u_src (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
        .cl_ready(cl_ready), .cl_bit(cl_bit), .cl_valid(cl_valid));

    always @(negedge core_clk)
    begin
        if (cl_ready === 1'b0)
            saw_full = 1'b1;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // reads one line byte starting at its first bit; judges position, stand and content
    task automatic read_byte();
        logic [7:0]        b;
        logic              oh0;
        logic              pv0;
        logic [INST_W-1:0] in0;
        logic [ROW_W-1:0]  rw0;
        int                fs;
        int                moved;
        oh0   = line_oh;
        pv0   = line_payload_valid;
        in0   = line_inst;
        rw0   = line_row;
        fs    = 0;
        moved = 0;
        b     = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            b = {b[6:0], line_bit};
            if (line_frame_start === 1'b1)
                fs++;
            if (line_oh !== oh0 || line_payload_valid !== pv0 || line_inst !== in0)
                moved++;
            @(negedge core_clk);
        end
        `CHK("frame start", (pos == 0) ? 1 : 0, fs)
        `CHK("byte fields stand", 0, moved)
        `CHK("line_row", ROW_W'(pos / FRAME_COLS), rw0)
        `CHK("line_oh", ((pos % FRAME_COLS) < OH_COLS) ? 1'b1 : 1'b0, oh0)
        `CHK("line_inst", INST_ONE, in0)
        if (oh0 === 1'b1)
            `CHK("overhead byte", ZERO_BYTE, b)
        else if (pv0 === 1'b1)
        begin
            `CHK("payload byte", exp_byte, b)
            exp_byte = exp_byte + 8'h3B;
        end
        else
        begin
            `CHK("empty slot byte", ZERO_BYTE, b)
            n_empty++;
        end
        pos++;
    endtask

    task automatic t_reset_state();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("reset line_bit", 1'b0, line_bit)
        `CHK("reset line_oh", 1'b0, line_oh)
        `CHK("reset payload_valid", 1'b0, line_payload_valid)
        `CHK("reset line_inst", INST_ONE, line_inst)
        `CHK("reset cl_ready", 1'b1, cl_ready)
        @(posedge core_clk);
        reset_n <= 1'b1;
    endtask

    task automatic t_overhead();
        int k;
        k        = 0;
        pos      = 0;
        exp_byte = 8'h5A;
        @(negedge core_clk);
        while (line_frame_start !== 1'b1 && k < 40)
        begin
            @(negedge core_clk);
            k++;
        end
        `CHK("first frame start", 1'b1, line_frame_start)
        repeat (OH_COLS) read_byte();
    endtask

    task automatic t_payload_fast();
        n_empty = 0;
        repeat (48) read_byte();
        `CHK("fast source empty slots", 0, n_empty)
    endtask

    // slow source drains the buffer; a new count must not act mid-frame
    task automatic t_payload_slow();
        slow    <= 1'b1;
        n_inst  <= @(posedge core_clk) INST_MAX;
        n_empty = 0;
        repeat (200) read_byte();
        `CHK("starved slot seen", 1'b1, n_empty > 0)
    endtask

    // overhead of rows 1 and 2 halts pops long enough for the buffer to refuse
    task automatic t_rows_refill();
        slow     <= 1'b0;
        saw_full = 1'b0;
        while (pos < 2 * FRAME_COLS + OH_COLS + 16)
            read_byte();
        `CHK("client refused when full", 1'b1, saw_full)
    endtask

    initial
    begin
        repeat (70000) @(posedge core_clk);
        n_mismatch++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end

    initial
    begin
        t_reset_state();
        t_overhead();
        t_payload_fast();
        t_payload_slow();
        t_rows_refill();
        t_reset_state();
        t_overhead();
        t_payload_fast();
        test_done();
    end
endmodule // obm_mapper_test
`default_nettype wire
